// File: logic/dmapc_buf2.sv
// Two-entry buffer with valid and ready on both sides and registered outputs.
// Assumes the pushing and popping sides run on the same clock.
module dmapc_buf2 #(
  parameter int unsigned W = 38
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] head_reg;
  logic [W-1:0] tail_reg;
  logic [1:0] cnt_reg;
  logic valid_reg;
  logic ready_reg;
  logic [1:0] cnt_next;
  wire push = in_valid_i && ready_reg;
  wire pop = valid_reg && out_ready_i;

  // A full buffer withdraws ready, so a stalled receiver loses no word.
  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cnt_reg <= 2'h0;
      valid_reg <= 1'b0;
      ready_reg <= 1'b1;
      head_reg <= '0;
      tail_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      valid_reg <= (cnt_next != 2'h0);
      ready_reg <= (cnt_next != 2'h2);
      if (pop && cnt_reg == 2'h2) begin
        head_reg <= tail_reg;
      end else if (push && (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop))) begin
        head_reg <= in_data_i;
      end
      if (push && cnt_reg == 2'h1 && !pop) begin
        tail_reg <= in_data_i;
      end
    end
  end

  assign in_ready_o = ready_reg;
  assign out_valid_o = valid_reg;
  assign out_data_o = head_reg;

  property p_buf_full_stalls;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (cnt_reg == 2'h2) |-> (!in_ready_o && out_valid_o);
  endproperty
  a_buf_full_stalls: assert property (p_buf_full_stalls) else $error("Full buffer still ready.");
endmodule

// File: logic/dmapc_pkg.sv
// Constants, types and helper functions of the DMA channel enable and pacing block.
// Assumes one 100 MHz system clock and a classic Wishbone register bus.
package dmapc_pkg;

  localparam int unsigned NUM_CH = 15;
  localparam int unsigned NUM_LINES = 32;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned PAGE_W = 4;
  localparam int unsigned CH_W = 4;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned PHYS_W = 34;

  localparam logic [7:0] ADR_ENABLE = 8'h00;
  localparam logic [7:0] ADR_LINES = 8'h04;
  localparam logic [7:0] ADR_CFG_BASE = 8'h40;
  localparam logic [7:0] ADR_CFG_LAST = 8'h78;

  localparam int unsigned EN_LSB = 0;
  localparam int unsigned PAGE_LSB = 24;
  localparam int unsigned PAGELITE_LSB = 28;
  localparam logic [NUM_CH-1:0] EN_RESET = 15'h7FFF;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 4'h0;
  localparam logic [PAGE_W-1:0] PAGELITE_RESET = 4'h0;

  localparam int unsigned CFG_SEL_LSB = 0;
  localparam int unsigned CFG_PACE_RD_BIT = 8;
  localparam int unsigned CFG_PACE_WR_BIT = 9;
  localparam int unsigned CFG_WAIT_FOR_WRITE_RESPONSE_BIT = 10;
  localparam int unsigned CFG_RD_BUSY_BIT = 16;
  localparam int unsigned CFG_WR_OUT_BIT = 17;
  localparam logic [SEL_W-1:0] CFG_SEL_RESET = 5'h00;

  localparam logic [CH_W-1:0] FULL_LAST_CH = 4'h6;
  localparam logic [CH_W-1:0] LITE_FIRST_CH = 4'h7;
  localparam logic [CH_W-1:0] LITE_LAST_CH = 4'hA;
  localparam logic [1:0] UNCACHED_TOP = 2'h3;
  localparam int unsigned PAGE_SHIFT = 30;

  localparam logic [NUM_LINES-1:0] LINES_RESET = 32'h0000_0001;
  localparam int unsigned SCALER_FIRST_LINE = 24;
  localparam int unsigned NUM_SCALER = 3;
  localparam int unsigned NUM_ALT = 5;

  typedef enum logic [0:0] {RD_IDLE, RD_WAIT} dmapc_rd_e;

  // Relocates an uncached-window address of channels 0 to 10 onto the SDRAM page of its engine class; higher channels pass through.
  function automatic logic [PHYS_W-1:0] dmapc_xlat(input logic [ADDR_W-1:0] a,
                                                   input logic [CH_W-1:0] ch,
                                                   input logic [PAGE_W-1:0] page,
                                                   input logic [PAGE_W-1:0] lite);
    logic [PHYS_W-1:0] r;
    r = {2'h0, a};
    if (a[ADDR_W-1:PAGE_SHIFT] == UNCACHED_TOP) begin
      if (ch <= FULL_LAST_CH) begin
        r = {page, a[PAGE_SHIFT-1:0]};
      end else if (ch >= LITE_FIRST_CH && ch <= LITE_LAST_CH) begin
        r = {lite, a[PAGE_SHIFT-1:0]};
      end
    end
    return r;
  endfunction

  // Merges write data into an old word under the byte enables.
  function automatic logic [31:0] dmapc_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] sel);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = sel[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
    end
    return r;
  endfunction

endpackage

// File: logic/dmapc_top.sv
// Channel enable register, SDRAM page relocation and pacing request logic of a DMA controller.
// Assumes classic Wishbone from software, level requests from engines, asynchronous pacing pins.
module dmapc_top
  import dmapc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_LINES-1:1] periph_req_i,
  input wire logic [NUM_ALT-1:0] alt_periph_req_i,
  input wire logic [NUM_ALT-1:0] alternate_request_mux_bits_i,
  input wire logic [NUM_SCALER-1:0] secondary_memory_port_req_i,
  input wire logic secondary_port_request_gate_i,
  input wire logic [NUM_CH-1:0] rd_req_i,
  input wire logic [NUM_CH-1:0] rd_room_i,
  input wire logic [NUM_CH-1:0] rd_done_i,
  output logic [NUM_CH-1:0] rd_grant_o,
  input wire logic [NUM_CH-1:0] wr_req_i,
  input wire logic [NUM_CH-1:0] wr_resp_i,
  output logic [NUM_CH-1:0] wr_grant_o,
  output logic [NUM_CH-1:0] chan_enable_o,
  input wire logic addr_valid_i,
  output logic addr_ready_o,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [CH_W-1:0] addr_chan_i,
  output logic phys_valid_o,
  input wire logic phys_ready_i,
  output logic [PHYS_W-1:0] phys_addr_o,
  output logic [CH_W-1:0] phys_chan_o
);

  // Register state.
  logic [NUM_CH-1:0] en_reg;
  logic [PAGE_W-1:0] page_reg;
  logic [PAGE_W-1:0] lite_reg;
  logic [SEL_W-1:0] sel_reg [NUM_CH];
  logic [NUM_CH-1:0] prd_reg;
  logic [NUM_CH-1:0] pwr_reg;
  logic [NUM_CH-1:0] wresp_reg;
  logic wb_ack_reg;
  logic [31:0] wb_dat_reg;

  // Pacing line synchroniser state.
  logic [NUM_LINES-1:0] raw_lines_w;
  logic [NUM_LINES-1:0] sync1_reg;
  logic [NUM_LINES-1:0] sync2_reg;
  logic [NUM_LINES-1:0] sync3_reg;
  logic [NUM_LINES-1:0] line_reg;
  logic [NUM_LINES-1:0] line_next;
  logic [NUM_LINES-1:0] lines_w;

  // Per-channel status seen by software.
  logic [NUM_CH-1:0] rd_busy_w;
  logic [NUM_CH-1:0] wr_out_w;
  logic [31:0] cfg_rd_w [NUM_CH];

  // Line composition ahead of the synchroniser.
  assign raw_lines_w[0] = 1'b1;
  assign raw_lines_w[1] = alternate_request_mux_bits_i[0] ? alt_periph_req_i[0]
                                                            : periph_req_i[1];
  assign raw_lines_w[18:2] = periph_req_i[18:2];
  assign raw_lines_w[22:19] = (alternate_request_mux_bits_i[4:1] & alt_periph_req_i[4:1])
                            | (~alternate_request_mux_bits_i[4:1] & periph_req_i[22:19]);
  assign raw_lines_w[23] = periph_req_i[23];
  assign raw_lines_w[26:24] = periph_req_i[26:24]
                            | (secondary_memory_port_req_i
                               & {NUM_SCALER{!secondary_port_request_gate_i}});
  assign raw_lines_w[31:27] = periph_req_i[31:27];

  // A bit moves only once the second and third stages agree.
  assign line_next = (~(sync2_reg ^ sync3_reg) & sync2_reg)
                   | ((sync2_reg ^ sync3_reg) & line_reg);
  assign lines_w = {line_reg[NUM_LINES-1:1], 1'b1};

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      sync1_reg <= LINES_RESET;
      sync2_reg <= LINES_RESET;
      sync3_reg <= LINES_RESET;
      line_reg <= LINES_RESET;
    end else begin
      sync1_reg <= raw_lines_w;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      line_reg <= line_next;
    end
  end

  // Register bus decode.
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_reg;
  wire wb_wr = wb_req && wb_we_i;
  wire hit_enable = (wb_adr_i[7:2] == ADR_ENABLE[7:2]);
  wire hit_lines = (wb_adr_i[7:2] == ADR_LINES[7:2]);
  wire hit_cfg = (wb_adr_i[7:2] >= ADR_CFG_BASE[7:2]) && (wb_adr_i[7:2] <= ADR_CFG_LAST[7:2]);
  wire [CH_W-1:0] cfg_idx = wb_adr_i[5:2];
  wire [31:0] enable_rd_w = {lite_reg, page_reg, 9'h000, en_reg};
  wire [31:0] en_merge_w = dmapc_merge(enable_rd_w, wb_dat_i, wb_sel_i);
  wire [31:0] cfg_cur_w = hit_cfg ? cfg_rd_w[cfg_idx] : 32'h0000_0000;
  wire [31:0] cfg_merge_w = dmapc_merge(cfg_cur_w, wb_dat_i, wb_sel_i);
  wire [31:0] rd_mux_w = hit_enable ? enable_rd_w
                       : hit_lines ? lines_w
                       : cfg_cur_w;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
    end else begin
      wb_ack_reg <= wb_req;
      if (wb_req) begin
        wb_dat_reg <= rd_mux_w;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      en_reg <= EN_RESET;
      page_reg <= PAGE_RESET;
      lite_reg <= PAGELITE_RESET;
    end else if (wb_wr && hit_enable) begin
      en_reg <= en_merge_w[EN_LSB +: NUM_CH];
      page_reg <= en_merge_w[PAGE_LSB +: PAGE_W];
      lite_reg <= en_merge_w[PAGELITE_LSB +: PAGE_W];
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;
  assign chan_enable_o = en_reg;

  // Per-channel pacing.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    dmapc_rd_e rd_state_reg;
    logic rd_grant_reg;
    logic wr_grant_reg;
    logic wr_out_reg;
    wire cfg_wr = wb_wr && hit_cfg && (cfg_idx == CH_W'(c));
    wire line_hi = lines_w[sel_reg[c]];
    wire rd_ok = prd_reg[c] ? line_hi : rd_room_i[c];
    wire rd_go = en_reg[c] && rd_req_i[c] && !rd_grant_reg && (rd_state_reg == RD_IDLE)
              && rd_ok;
    wire wr_ok = (pwr_reg[c] ? line_hi : 1'b1) && !(wresp_reg[c] && wr_out_reg);
    wire wr_go = en_reg[c] && wr_req_i[c] && !wr_grant_reg && wr_ok;

    always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
        sel_reg[c] <= CFG_SEL_RESET;
        prd_reg[c] <= 1'b0;
        pwr_reg[c] <= 1'b0;
        wresp_reg[c] <= 1'b0;
      end else if (cfg_wr) begin
        sel_reg[c] <= cfg_merge_w[CFG_SEL_LSB +: SEL_W];
        prd_reg[c] <= cfg_merge_w[CFG_PACE_RD_BIT];
        pwr_reg[c] <= cfg_merge_w[CFG_PACE_WR_BIT];
        wresp_reg[c] <= cfg_merge_w[CFG_WAIT_FOR_WRITE_RESPONSE_BIT];
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
        rd_state_reg <= RD_IDLE;
        rd_grant_reg <= 1'b0;
        wr_grant_reg <= 1'b0;
        wr_out_reg <= 1'b0;
      end else begin
        rd_grant_reg <= rd_go;
        wr_grant_reg <= wr_go;
        wr_out_reg <= wr_go || (wr_out_reg && !wr_resp_i[c]);
        case (rd_state_reg)
          RD_IDLE: begin
            if (rd_go && prd_reg[c]) begin
              rd_state_reg <= RD_WAIT;
            end
          end
          RD_WAIT: begin
            if (rd_done_i[c]) begin
              rd_state_reg <= RD_IDLE;
            end
          end
          default: begin
            rd_state_reg <= RD_IDLE;
          end
        endcase
      end
    end

    assign rd_grant_o[c] = rd_grant_reg;
    assign wr_grant_o[c] = wr_grant_reg;
    assign rd_busy_w[c] = (rd_state_reg == RD_WAIT);
    assign wr_out_w[c] = wr_out_reg;
    assign cfg_rd_w[c] = {14'h0000, wr_out_w[c], rd_busy_w[c], 5'h00, wresp_reg[c], pwr_reg[c],
                          prd_reg[c], 3'h0, sel_reg[c]};

    property p_rd_paced;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (rd_grant_reg && $past(prd_reg[c])) |-> $past(line_hi);
    endproperty
    a_rd_paced: assert property (p_rd_paced) else $error("Paced read without request.");

    property p_rd_hold;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (rd_state_reg == RD_WAIT && !rd_done_i[c]) |=> !rd_grant_reg;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("Read granted before beats returned.");

    property p_rd_enter_wait;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (rd_grant_reg && $past(prd_reg[c])) |-> (rd_state_reg == RD_WAIT);
    endproperty
    a_rd_enter_wait: assert property (p_rd_enter_wait) else $error("Paced read not held.");

    property p_rd_room;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (rd_grant_reg && !$past(prd_reg[c])) |-> $past(rd_room_i[c]);
    endproperty
    a_rd_room: assert property (p_rd_room) else $error("Unpaced read without room.");

    property p_wr_paced;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr_grant_reg && $past(pwr_reg[c])) |-> $past(line_hi);
    endproperty
    a_wr_paced: assert property (p_wr_paced) else $error("Paced write without request.");

    property p_wr_one_out;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (wresp_reg[c] && wr_out_reg && !wr_resp_i[c]) |=> !wr_grant_reg;
    endproperty
    a_wr_one_out: assert property (p_wr_one_out) else $error("Second write in flight.");

    property p_disabled_idle;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      !$past(en_reg[c]) |-> (!rd_grant_reg && !wr_grant_reg);
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("Disabled engine granted.");

    property p_rd_release;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (rd_state_reg == RD_WAIT && rd_done_i[c]) |=> (rd_state_reg == RD_IDLE);
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("Busy read not released.");

    property p_rd_pulse;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      rd_grant_reg |=> !rd_grant_reg;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("Read grant held too long.");

    property p_rd_needs_req;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      rd_grant_reg |-> $past(rd_req_i[c]);
    endproperty
    a_rd_needs_req: assert property (p_rd_needs_req) else $error("Read granted unasked.");

    property p_wr_needs_req;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      wr_grant_reg |-> $past(wr_req_i[c]);
    endproperty
    a_wr_needs_req: assert property (p_wr_needs_req) else $error("Write granted unasked.");
  end

  // Uncached-window relocation feeding the address buffer.
  wire [PHYS_W-1:0] xlat_w = dmapc_xlat(addr_i, addr_chan_i, page_reg, lite_reg);

  dmapc_buf2 #(
    .W(PHYS_W + CH_W)
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(addr_valid_i),
    .in_ready_o(addr_ready_o),
    .in_data_i({addr_chan_i, xlat_w}),
    .out_valid_o(phys_valid_o),
    .out_ready_i(phys_ready_i),
    .out_data_o({phys_chan_o, phys_addr_o})
  );

  property p_line0_high;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    lines_w[0] && wb_ack_reg |-> (!$past(hit_lines) || wb_dat_o[0]);
  endproperty
  a_line0_high: assert property (p_line0_high) else $error("Line zero read low.");

  property p_ack_pulse;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held too long.");

  property p_ack_follows;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("Request not acknowledged.");

  property p_unmapped_zero;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (wb_req && !wb_we_i && !hit_enable && !hit_lines && !hit_cfg) |=> (wb_dat_o == 32'h0000_0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("Unmapped read not zero.");

  property p_xlat_pass;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (addr_i[31:30] != UNCACHED_TOP || addr_chan_i > LITE_LAST_CH)
      |-> (xlat_w == {2'h0, addr_i});
  endproperty
  a_xlat_pass: assert property (p_xlat_pass) else $error("Address moved outside window.");

  property p_sync_agree;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    ##1 (((line_reg ^ $past(line_reg)) & $past(sync2_reg ^ sync3_reg)) == 32'h0000_0000);
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("Line moved on disagreement.");

  property p_en_write;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (wb_wr && hit_enable && wb_sel_i[1:0] == 2'h3) |=> (chan_enable_o == $past(wb_dat_i[14:0]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("Enable write not applied.");

  property p_page_full;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (addr_i[31:30] == UNCACHED_TOP && addr_chan_i <= FULL_LAST_CH)
      |-> (xlat_w == {page_reg, addr_i[29:0]});
  endproperty
  a_page_full: assert property (p_page_full) else $error("Full engine page wrong.");

  property p_page_lite;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (addr_i[31:30] == UNCACHED_TOP && addr_chan_i >= LITE_FIRST_CH && addr_chan_i <= LITE_LAST_CH)
      |-> (xlat_w == {lite_reg, addr_i[29:0]});
  endproperty
  a_page_lite: assert property (p_page_lite) else $error("Lite engine page wrong.");

  property p_scaler_gate;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    secondary_port_request_gate_i |-> (raw_lines_w[26:24] == periph_req_i[26:24]);
  endproperty
  a_scaler_gate: assert property (p_scaler_gate) else $error("Gated port still requests.");

  property p_buf_order;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (phys_valid_o && !phys_ready_i) |=> (phys_valid_o && $stable(phys_addr_o));
  endproperty
  a_buf_order: assert property (p_buf_order) else $error("Stalled word changed.");

endmodule

// File: test/dmapc_periph.sv
// Behavioural model of a peripheral that paces one channel over one pacing line.
// Assumes the bench raises fire_i only when data is ready or FIFO room exists.
module dmapc_periph
  import dmapc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic fire_i,
  input wire logic grant_i,
  input wire logic [SEL_W-1:0] line_i,
  output logic [NUM_LINES-1:1] req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_reg;

  // The request drops on the grant and rises only when the bench says it may.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pend_reg <= 1'b0;
    end else if (grant_i) begin
      pend_reg <= 1'b0;
    end else if (fire_i) begin
      pend_reg <= 1'b1;
    end
  end

  always_comb begin
    req_o = '0;
    if (line_i != 5'h00) begin
      req_o[line_i] = pend_reg;
    end
  end
endmodule

// File: test/testbench.sv
// Self-checking bench of the DMA channel enable and pacing block.
// Assumes the peripheral model is compiled before it and drives the pacing pins.
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t got %h expected %h", $time, (a), (e)); end end
module testbench
  import dmapc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0;
  logic gate = 1'b0, av = 1'b0, pr = 1'b1, ack, ar, pv;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000, q, rdat;
  logic [NUM_CH-1:0] rd_req = '0, rd_room = '0, rd_done = '0, wr_req = '0, wr_resp = '0;
  logic [NUM_CH-1:0] rd_grant, wr_grant, chan_en;
  logic [NUM_ALT-1:0] alt = '0, mux = '0;
  logic [NUM_SCALER-1:0] sec = '0;
  logic [ADDR_W-1:0] addr = '0;
  logic [CH_W-1:0] ach = '0, pch;
  logic [PHYS_W-1:0] paddr;
  logic [NUM_LINES-1:1] preq;
  int error_cnt = 0, tests_run = 0, cycles = 0, n;
  int rdg [NUM_CH] = '{default: 0};
  int wrg [NUM_CH] = '{default: 0};
  logic [71:0] reg_rows [5] = '{{8'h00, 32'hFFFF_FFFF, 32'hFF00_7FFF},
    {8'h00, 32'h9500_3FFF, 32'h9500_3FFF}, {8'h20, 32'hFFFF_FFFF, 32'h0000_0000},
    {8'h48, 32'h0003_0105, 32'h0000_0105}, {8'h04, 32'hFFFF_FFFE, 32'h0000_0001}};
  logic [45:0] line_rows [6] = '{{3'h1, 1'h0, 5'h00, 5'h00, 32'h0100_0001},
    {3'h1, 1'h1, 5'h00, 5'h00, 32'h0000_0001}, {3'h4, 1'h0, 5'h00, 5'h00, 32'h0400_0001},
    {3'h0, 1'h0, 5'h02, 5'h02, 32'h0008_0001}, {3'h0, 1'h0, 5'h01, 5'h00, 32'h0000_0001},
    {3'h0, 1'h0, 5'h1F, 5'h1F, 32'h0078_0003}};
  logic [69:0] xl_rows [6] = '{{4'h0, 32'hC000_1234, 34'h1_4000_1234},
    {4'h6, 32'hFFFF_FFFC, 34'h1_7FFF_FFFC}, {4'h7, 32'hC000_0010, 34'h2_4000_0010},
    {4'hA, 32'hC000_0010, 34'h2_4000_0010}, {4'hB, 32'hC000_0010, 34'h0_C000_0010},
    {4'h0, 32'h8000_0000, 34'h0_8000_0000}};

  always #5 clk = ~clk;

  dmapc_periph peri (.sys_clk_i(clk), .resetn_i(resetn), .fire_i(fire),
    .grant_i(rd_grant[2]), .line_i(5'h05), .req_o(preq));

  dmapc_top uut (.sys_clk_i(clk), .resetn_i(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .periph_req_i(preq), .alt_periph_req_i(alt),
    .alternate_request_mux_bits_i(mux), .secondary_memory_port_req_i(sec),
    .secondary_port_request_gate_i(gate), .rd_req_i(rd_req), .rd_room_i(rd_room),
    .rd_done_i(rd_done), .rd_grant_o(rd_grant), .wr_req_i(wr_req), .wr_resp_i(wr_resp),
    .wr_grant_o(wr_grant), .chan_enable_o(chan_en), .addr_valid_i(av), .addr_ready_o(ar),
    .addr_i(addr), .addr_chan_i(ach), .phys_valid_o(pv), .phys_ready_i(pr),
    .phys_addr_o(paddr), .phys_chan_o(pch));

  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    for (int i = 0; i < NUM_CH; i++) begin
      rdg[i] += (rd_grant[i] === 1'b1);
      wrg[i] += (wr_grant[i] === 1'b1);
    end
    if (cycles > 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pop(input logic [PHYS_W-1:0] e, input logic [CH_W-1:0] c);
    do @(posedge clk); while (pv !== 1'b1);
    `CHK(paddr, e)
    `CHK(pch, c)
  endtask

  initial begin
    tick(10);
    resetn <= 1'b1;
    tick(1);
    `CHK(chan_en, 15'h7FFF)
    wb(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h0000_7FFF)
    foreach (reg_rows[i]) begin
      wb(1'b1, reg_rows[i][71:64], reg_rows[i][63:32]);
      wb(1'b0, reg_rows[i][71:64], 32'h0);
      `CHK(q, reg_rows[i][31:0])
    end
    `CHK(chan_en, 15'h3FFF)
    foreach (line_rows[i]) begin
      {sec, gate, alt, mux} <= line_rows[i][45:32];
      tick(8);
      wb(1'b0, 8'h04, 32'h0);
      `CHK(q, line_rows[i][31:0])
    end
    foreach (xl_rows[i]) begin
      av <= 1'b1; ach <= xl_rows[i][69:66]; addr <= xl_rows[i][65:34];
      do @(posedge clk); while (ar !== 1'b1);
      av <= 1'b0;
      pop(xl_rows[i][33:0], xl_rows[i][69:66]);
    end
    pr <= 1'b0; av <= 1'b1; ach <= 4'h0; addr <= 32'hC000_0000; n = 0;
    repeat (6) begin
      @(posedge clk);
      if (ar === 1'b1) begin
        n++;
        addr <= addr + 32'h4;
      end
    end
    av <= 1'b0;
    `CHK(n, 2)
    pr <= 1'b1;
    pop(34'h1_4000_0000, 4'h0);
    pop(34'h1_4000_0004, 4'h0);
    rd_req[2] <= 1'b1;
    tick(8);
    `CHK(rdg[2], 0)
    fire <= 1'b1; tick(1); fire <= 1'b0; tick(10);
    `CHK(rdg[2], 1)
    fire <= 1'b1; tick(1); fire <= 1'b0; tick(10);
    `CHK(rdg[2], 1)
    rd_done[2] <= 1'b1; tick(1); rd_done[2] <= 1'b0; tick(10);
    `CHK(rdg[2], 2)
    rd_req[2] <= 1'b0;
    wb(1'b1, 8'h4C, 32'h0000_0100);
    rd_req[3] <= 1'b1; rd_req[4] <= 1'b1; rd_req[14] <= 1'b1; rd_room[14] <= 1'b1;
    tick(8);
    `CHK(rdg[3], 1)
    `CHK(rdg[4], 0)
    `CHK(rdg[14], 0)
    wb(1'b0, 8'h4C, 32'h0);
    `CHK(q, 32'h0001_0100)
    rd_room[4] <= 1'b1;
    wb(1'b1, 8'h00, 32'h9500_7FFF);
    tick(8);
    `CHK(rdg[4] > 0, 1'b1)
    `CHK(rdg[14] > 0, 1'b1)
    rd_req <= '0;
    wb(1'b1, 8'h54, 32'h0000_0605);
    wr_req[5] <= 1'b1;
    tick(8);
    `CHK(wrg[5], 0)
    fire <= 1'b1; tick(1); fire <= 1'b0; tick(10);
    `CHK(wrg[5], 1)
    wb(1'b0, 8'h54, 32'h0);
    `CHK(q, 32'h0002_0605)
    wr_resp[5] <= 1'b1; tick(1); wr_resp[5] <= 1'b0; tick(6);
    `CHK(wrg[5], 2)
    wb(1'b1, 8'h54, 32'h0000_0005);
    tick(6);
    `CHK(wrg[5] > 2, 1'b1)
    wr_req[5] <= 1'b0;
    resetn <= 1'b0; tick(2); resetn <= 1'b1; tick(1);
    wb(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h0000_7FFF)
    end_of_test();
  end
endmodule
